// ==== src/rsq_pkg.sv ====
package rsq_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register addresses and the watchdog service address.
  localparam logic [15:0] ADDR_CFG_TWO     = 16'h001E;
  localparam logic [15:0] ADDR_CFG_ONE     = 16'h001F;
  localparam logic [15:0] ADDR_CAUSE       = 16'hFE00;
  localparam logic [15:0] ADDR_BRK_AUX     = 16'hFE02;
  localparam logic [15:0] ADDR_WDOG_SERVICE = 16'hFFFF;

  // Field positions.
  localparam int CFG2_PINEN_BIT  = 0;
  localparam int CFG1_STOPEN_BIT = 0;
  localparam int CFG1_QREC_BIT   = 1;
  localparam int BRK_WDDIS_BIT   = 0;
  localparam int CAUSE_POR_BIT   = 7;
  localparam int CAUSE_PIN_BIT   = 6;
  localparam int CAUSE_WDOG_BIT  = 5;
  localparam int CAUSE_BADOP_BIT = 4;
  localparam int CAUSE_BADAD_BIT = 3;
  localparam int CAUSE_LOWV_BIT  = 1;

  // Reset values.
  localparam logic [7:0] CFG_ONE_RESET = 8'h00;
  localparam logic [7:0] CFG_TWO_RESET = 8'h00;
  localparam logic [7:0] BRK_AUX_RESET = 8'h00;

  // Timing counts in quad clock cycles.
  localparam int SYS_CNT_W        = 12;
  localparam int POR_WAIT_CYCLES  = 4096;
  localparam int PIN_DRIVE_CYCLES = 32;
  localparam int RST_HOLD_CYCLES  = 32;
  localparam int TAIL_CYCLES      = 3;
  localparam int STOP_SHORT_CYCLES = 32;
  localparam int STOP_LONG_CYCLES = 4096;
  localparam int SEQ_CNT_W        = 7;
  localparam int QUAD_DIV         = 4;
  localparam int SVC_CLR_LO       = 4;   // Lowest counter bit that a service write clears.

  // Reset cause flags.
  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic bad_op;
    logic bad_adr;
    logic lowv;
  } rsq_cause_t;

  localparam rsq_cause_t CAUSE_RESET = '{por: 1'b1, default: 1'b0};

  // Events reported by the processor core.
  typedef struct packed {
    logic illegal_op;
    logic stop_exec;
    logic opcode_fetch;
    logic unmapped;
  } rsq_cpu_evt_t;

  // Register bus request.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } rsq_bus_req_t;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_LOWV_HOLD,
    ST_POR_WAIT,
    ST_PIN_LOW,
    ST_RST_HOLD,
    ST_TAIL,
    ST_RUN,
    ST_STOP,
    ST_STOP_REC,
    ST_EXT_HOLD
  } rsq_state_t;

endpackage : rsq_pkg

// ==== src/rsq_reset_sequencer.sv ====
`timescale 1ns/1ps
module rsq_reset_sequencer
  import rsq_pkg::*;
#(
  parameter int WD_BITS         = 6,   // Watchdog counter width.
  parameter int PIN_MIN_LOW_CYC = 4    // Minimum external low time in cycles.
) (
  input  wire logic         mclk,               // Quad bus clock, 10 MHz.
  input  wire logic         resetn,             // Asynchronous reset, active low.
  input  wire rsq_bus_req_t bus,                // Register bus request.
  output logic [7:0]        rdata,              // Read data, cycle after read strobe.
  input  wire logic         power_on_pulse,     // Power-on pulse.
  input  wire logic         low_voltage_detect, // Supply below trip level.
  input  wire rsq_cpu_evt_t cpu_evt,            // Processor event flags.
  input  wire logic         wake_event,         // Interrupt or break ending stop.
  input  wire logic         break_active,       // Break interrupt in progress.
  input  wire logic         monitor_mode,       // Monitor mode active.
  input  wire logic         rst_pin_in,         // Reset pin level.
  output logic              rst_pin_out,        // Reset pin drive value.
  output logic              rst_pin_oe,         // Reset pin drive enable.
  output logic              internal_reset,     // Internal reset, active high.
  output logic              osc_enable,         // Oscillator enable.
  output logic              cpu_clk_run,        // Processor and module clocks run.
  output logic              bus_clk_en          // One-cycle bus clock enable.
);

  // Refuse watchdog and pin filter sizes the counters cannot hold.
  if (WD_BITS < 2 || WD_BITS > 16) begin : g_bad_wd
    $error("rsq_reset_sequencer: WD_BITS must lie in 2..16");
  end
  if (PIN_MIN_LOW_CYC < 1 || PIN_MIN_LOW_CYC > 255) begin : g_bad_pin
    $error("rsq_reset_sequencer: PIN_MIN_LOW_CYC must lie in 1..255");
  end

  localparam logic [SEQ_CNT_W-1:0] PIN_LAST  = SEQ_CNT_W'(PIN_DRIVE_CYCLES - 1);
  localparam logic [SEQ_CNT_W-1:0] HOLD_LAST = SEQ_CNT_W'(RST_HOLD_CYCLES - 1);
  localparam logic [SEQ_CNT_W-1:0] TAIL_LAST = SEQ_CNT_W'(TAIL_CYCLES - 1);
  localparam logic [SYS_CNT_W-1:0] POR_LAST  = SYS_CNT_W'(POR_WAIT_CYCLES - 1);
  localparam logic [SYS_CNT_W-1:0] SREC_SHORT = SYS_CNT_W'(STOP_SHORT_CYCLES - 1);
  localparam logic [SYS_CNT_W-1:0] SREC_LONG = SYS_CNT_W'(STOP_LONG_CYCLES - 1);
  localparam logic [7:0]           PIN_MIN   = 8'(PIN_MIN_LOW_CYC);
  localparam logic [1:0]           DIV_LAST  = 2'(QUAD_DIV - 1);

  // Packs cause flags into the status byte; unused bits read as zero.
  function automatic logic [7:0] cause_byte(input rsq_cause_t c);
    logic [7:0] b;
    b = 8'h00;
    b[CAUSE_POR_BIT]  = c.por;
    b[CAUSE_PIN_BIT]  = c.pin;
    b[CAUSE_WDOG_BIT] = c.wdog;
    b[CAUSE_BADOP_BIT] = c.bad_op;
    b[CAUSE_BADAD_BIT] = c.bad_adr;
    b[CAUSE_LOWV_BIT]  = c.lowv;
    return b;
  endfunction : cause_byte

  // True for states in which internal reset is asserted.
  function automatic logic in_reset(input rsq_state_t s);
    return (s == ST_LOWV_HOLD) || (s == ST_POR_WAIT) || (s == ST_PIN_LOW) ||
           (s == ST_RST_HOLD) || (s == ST_EXT_HOLD);
  endfunction : in_reset

  // Register file state.
  logic [7:0]   cfg_one;
  logic [7:0]   cfg_two;
  logic [7:0]   brk_aux;
  rsq_cause_t   cause;
  logic [7:0]   next_cfg_one;
  logic [7:0]   next_cfg_two;
  logic [7:0]   next_brk_aux;
  rsq_cause_t   next_cause;
  logic [7:0]   next_rdata;

  // Sequencer state.
  rsq_state_t            state;
  rsq_state_t            next_state;
  logic [SEQ_CNT_W-1:0]  seq_cnt;
  logic [SEQ_CNT_W-1:0]  next_seq_cnt;
  logic                  from_lowv;
  logic                  next_from_lowv;
  logic [7:0]            pin_low_cnt;
  logic [7:0]            next_pin_low_cnt;
  logic                  sys_clr;
  logic                  next_sys_clr;
  logic [1:0]            div;
  logic [1:0]            next_div;
  logic                  next_rst_pin_oe;
  logic                  next_internal_reset;
  logic                  next_osc_enable;
  logic                  next_cpu_clk_run;
  logic                  next_bus_clk_en;

  // System counter, falling edge domain of the same clock.
  logic [SYS_CNT_W-1:0]  sys_cnt;
  logic [SYS_CNT_W-1:0]  next_sys_cnt;
  logic                  wd_tog;
  logic                  next_wd_tog;
  logic                  sys_hold;

  // Watchdog state.
  logic [WD_BITS-1:0]    wd_cnt;
  logic [WD_BITS-1:0]    next_wd_cnt;
  logic                  wd_tog_seen;
  logic                  wd_req;
  logic                  next_wd_req;
  logic                  wd_sync1;
  logic                  wd_sync2;

  // Decoded strobes and conditions used by several processes.
  logic svc;
  logic pin_fn;
  logic quick_rec;
  logic wd_run;
  logic ext_low;

  // Register and pin decodes.
  always_comb begin
    svc     = bus.wr && (bus.addr == ADDR_WDOG_SERVICE);
    pin_fn    = cfg_two[CFG2_PINEN_BIT];
    quick_rec = cfg_one[CFG1_QREC_BIT];
    wd_run  = (state == ST_RUN) &&
              !(break_active && monitor_mode && brk_aux[BRK_WDDIS_BIT]);
    ext_low = pin_fn && !rst_pin_in && !rst_pin_oe;
    sys_hold = (state == ST_STOP);
  end

  // System counter next value. A service write clears only the upper stages, so
  // the prescaler keeps its low phase and the watchdog period stays bounded.
  always_comb begin
    next_sys_cnt = sys_cnt + 1'b1;
    next_wd_tog  = wd_tog;
    if (sys_clr) begin
      next_sys_cnt = '0;
    end else if (sys_hold) begin
      next_sys_cnt = sys_cnt;
    end else if (svc) begin
      next_sys_cnt = {{(SYS_CNT_W-SVC_CLR_LO){1'b0}}, sys_cnt[SVC_CLR_LO-1:0]};
    end else if (&sys_cnt) begin
      next_wd_tog = !wd_tog;
    end
  end

  // The counter moves on the falling edge; external reset never touches it.
  always_ff @(negedge mclk or negedge resetn) begin
    if (!resetn) begin
      sys_cnt <= '0;
      wd_tog  <= 1'b0;
    end else begin
      sys_cnt <= next_sys_cnt;
      wd_tog  <= next_wd_tog;
    end
  end

  // Watchdog counter: advanced by the thirteenth stage, cleared by service.
  always_comb begin
    next_wd_cnt = wd_cnt;
    next_wd_req = wd_req;
    if (internal_reset) begin
      next_wd_cnt = '0;
      next_wd_req = 1'b0;
    end else if (svc) begin
      next_wd_cnt = '0;
    end else if (wd_run && (wd_tog != wd_tog_seen)) begin
      next_wd_cnt = wd_cnt + 1'b1;
      if (&wd_cnt) begin
        next_wd_req = 1'b1;
      end
    end
  end

  // Watchdog registers and the two-stage crossing of its reset request.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wd_cnt      <= '0;
      wd_tog_seen <= 1'b0;
      wd_req      <= 1'b0;
      wd_sync1    <= 1'b0;
      wd_sync2    <= 1'b0;
    end else begin
      wd_cnt      <= next_wd_cnt;
      wd_tog_seen <= wd_tog;
      wd_req      <= next_wd_req;
      wd_sync1    <= wd_req;
      wd_sync2    <= wd_sync1;
    end
  end

  // Reset sequencer. Priority: low voltage, power-on, watchdog, illegal opcode,
  // illegal address, then the external pin.
  always_comb begin
    next_state       = state;
    next_seq_cnt     = seq_cnt + 1'b1;
    next_from_lowv   = from_lowv;
    next_sys_clr     = 1'b0;
    next_cause       = '0;    // Only the flags that hardware sets in this cycle.
    next_pin_low_cnt = ext_low ? ((pin_low_cnt == PIN_MIN) ? PIN_MIN : pin_low_cnt + 1'b1)
                               : 8'h00;
    case (state)
      ST_LOWV_HOLD: begin
        next_seq_cnt = '0;
        next_sys_clr = 1'b1;
        if (!low_voltage_detect) begin
          next_state = ST_POR_WAIT;
        end
      end
      ST_POR_WAIT: begin
        next_seq_cnt = '0;
        if (sys_cnt == POR_LAST) begin
          next_state = ST_PIN_LOW;
        end
      end
      ST_PIN_LOW: begin
        if (seq_cnt == PIN_LAST) begin
          next_state   = ST_RST_HOLD;
          next_seq_cnt = '0;
        end
      end
      ST_RST_HOLD: begin
        if (seq_cnt == HOLD_LAST) begin
          next_state   = ST_TAIL;
          next_seq_cnt = '0;
        end
      end
      ST_TAIL: begin
        if (seq_cnt == TAIL_LAST) begin
          next_state    = ST_RUN;
          next_seq_cnt  = '0;
          next_from_lowv = 1'b0;
        end
      end
      ST_EXT_HOLD: begin
        next_seq_cnt = '0;
        if (rst_pin_in) begin
          next_state = ST_RST_HOLD;
        end
      end
      ST_STOP: begin
        next_seq_cnt = '0;
        if (wake_event) begin
          next_state = ST_STOP_REC;
        end
      end
      ST_STOP_REC: begin
        next_seq_cnt = '0;
        if (sys_cnt == (quick_rec ? SREC_SHORT : SREC_LONG)) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_seq_cnt = '0;
        if (cpu_evt.stop_exec && cfg_one[CFG1_STOPEN_BIT]) begin
          next_state   = ST_STOP;
          next_sys_clr = 1'b1;
        end
      end
      default: begin
        next_state   = ST_POR_WAIT;
        next_seq_cnt = '0;
      end
    endcase

    // Causes that are only meaningful while the processor runs or sleeps.
    if ((state == ST_RUN) || (state == ST_STOP) || (state == ST_STOP_REC)) begin
      if ((state == ST_RUN) && wd_sync2) begin
        next_cause.wdog = 1'b1;
        next_state      = ST_PIN_LOW;
        next_seq_cnt    = '0;
        next_sys_clr    = 1'b1;
      end else if ((state == ST_RUN) && (cpu_evt.illegal_op ||
                   (cpu_evt.stop_exec && !cfg_one[CFG1_STOPEN_BIT]))) begin
        next_cause.bad_op = 1'b1;
        next_state      = ST_PIN_LOW;
        next_seq_cnt    = '0;
        next_sys_clr    = 1'b1;
      end else if ((state == ST_RUN) && cpu_evt.opcode_fetch && cpu_evt.unmapped) begin
        next_cause.bad_adr = 1'b1;
        next_state      = ST_PIN_LOW;
        next_seq_cnt    = '0;
        next_sys_clr    = 1'b1;
      end else if (ext_low && (pin_low_cnt == PIN_MIN)) begin
        next_cause.pin  = 1'b1;
        next_state      = ST_EXT_HOLD;
      end
    end

    // Supply events override everything and restart the long sequence.
    if (low_voltage_detect) begin
      next_cause.lowv = 1'b1;
      next_state     = ST_LOWV_HOLD;
      next_from_lowv = 1'b1;
      next_seq_cnt   = '0;
      next_sys_clr   = 1'b1;
    end else if (power_on_pulse) begin
      next_cause.por = 1'b1;
      next_state     = ST_POR_WAIT;
      next_from_lowv = 1'b0;
      next_seq_cnt   = '0;
      next_sys_clr   = 1'b1;
    end

    // Pin drive is low-only; the pull-up gives the high level.
    next_rst_pin_oe     = next_cfg_two[CFG2_PINEN_BIT] && !low_voltage_detect &&
                          !power_on_pulse && ((next_state == ST_PIN_LOW) ||
                          ((next_state == ST_POR_WAIT) && next_from_lowv));
    next_internal_reset = in_reset(next_state);
    next_osc_enable     = (next_state != ST_STOP);
    next_cpu_clk_run    = !((next_state == ST_LOWV_HOLD) || (next_state == ST_POR_WAIT) ||
                            (next_state == ST_STOP) || (next_state == ST_STOP_REC));
    next_div            = next_cpu_clk_run ? div + 1'b1 : 2'b00;
    next_bus_clk_en     = next_cpu_clk_run && (div == DIV_LAST);
  end

  // Sequencer registers; reset enters the power-on wait.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state          <= ST_POR_WAIT;
      seq_cnt        <= '0;
      from_lowv      <= 1'b0;
      pin_low_cnt    <= 8'h00;
      sys_clr        <= 1'b1;
      div            <= 2'b00;
      rst_pin_oe     <= 1'b0;
      internal_reset <= 1'b1;
      osc_enable     <= 1'b1;
      cpu_clk_run    <= 1'b0;
      bus_clk_en     <= 1'b0;
    end else begin
      state          <= next_state;
      seq_cnt        <= next_seq_cnt;
      from_lowv      <= next_from_lowv;
      pin_low_cnt    <= next_pin_low_cnt;
      sys_clr        <= next_sys_clr;
      div            <= next_div;
      rst_pin_oe     <= next_rst_pin_oe;
      internal_reset <= next_internal_reset;
      osc_enable     <= next_osc_enable;
      cpu_clk_run    <= next_cpu_clk_run;
      bus_clk_en     <= next_bus_clk_en;
    end
  end

  // The pin is never driven high.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_pin_out <= 1'b0;
    end else begin
      rst_pin_out <= 1'b0;
    end
  end

  // Register writes and reads. Cause flags clear by writing ones; a hardware
  // set in the same cycle wins because it is applied last.
  always_comb begin
    next_cfg_one = cfg_one;
    next_cfg_two = cfg_two;
    next_brk_aux = brk_aux;
    next_rdata   = 8'h00;
    if (bus.wr) begin
      case (bus.addr)
        ADDR_CFG_ONE: next_cfg_one = bus.wdata;
        ADDR_CFG_TWO: next_cfg_two = bus.wdata;
        ADDR_BRK_AUX: next_brk_aux = bus.wdata;
        default: begin
        end
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CFG_ONE: next_rdata = cfg_one;
        ADDR_CFG_TWO: next_rdata = cfg_two;
        ADDR_BRK_AUX: next_rdata = brk_aux;
        ADDR_CAUSE:   next_rdata = cause_byte(cause);
        default:      next_rdata = 8'h00;
      endcase
    end
  end

  // Cause clear mask from software, merged with hardware sets.
  rsq_cause_t clr_mask;
  always_comb begin
    clr_mask = '0;
    if (bus.wr && (bus.addr == ADDR_CAUSE)) begin
      clr_mask.por  = bus.wdata[CAUSE_POR_BIT];
      clr_mask.pin  = bus.wdata[CAUSE_PIN_BIT];
      clr_mask.wdog = bus.wdata[CAUSE_WDOG_BIT];
      clr_mask.bad_op  = bus.wdata[CAUSE_BADOP_BIT];
      clr_mask.bad_adr = bus.wdata[CAUSE_BADAD_BIT];
      clr_mask.lowv    = bus.wdata[CAUSE_LOWV_BIT];
    end
  end

  // cfg_one and cfg_two survive the short resets and only a power event restores them; brk_aux clears on any internal reset.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_one <= CFG_ONE_RESET;
      cfg_two <= CFG_TWO_RESET;
      brk_aux <= BRK_AUX_RESET;
      cause   <= CAUSE_RESET;
      rdata   <= 8'h00;
    end else begin
      cfg_one <= (power_on_pulse || low_voltage_detect) ? CFG_ONE_RESET : next_cfg_one;
      cfg_two <= (power_on_pulse || low_voltage_detect) ? CFG_TWO_RESET : next_cfg_two;
      brk_aux <= internal_reset ? BRK_AUX_RESET : next_brk_aux;
      cause   <= (cause & ~clr_mask) | next_cause;
      rdata   <= next_rdata;
    end
  end

endmodule : rsq_reset_sequencer

// ==== verif/rsq_reset_sequencer_checker.sv ====
`timescale 1ns/1ps
module rsq_reset_sequencer_checker
  import rsq_pkg::*;
#(
  parameter int WD_BITS         = 6, // Watchdog width.
  parameter int PIN_MIN_LOW_CYC = 4  // Pin filter.
) (
  input wire logic         mclk,               // Clock.
  input wire logic         resetn,             // Reset.
  input wire rsq_bus_req_t bus,                // Bus.
  input wire logic [7:0]   rdata,              // Data.
  input wire logic         power_on_pulse,     // Power-on.
  input wire logic         low_voltage_detect, // Supply.
  input wire rsq_cpu_evt_t cpu_evt,            // Events.
  input wire logic         wake_event,         // Wake.
  input wire logic         break_active,       // Break.
  input wire logic         monitor_mode,       // Monitor.
  input wire logic         rst_pin_in,         // Pin.
  input wire logic         rst_pin_out,        // Value.
  input wire logic         rst_pin_oe,         // Enable.
  input wire logic         internal_reset,     // Reset out.
  input wire logic         osc_enable,         // Oscillator.
  input wire logic         cpu_clk_run,        // Clocks.
  input wire logic         bus_clk_en          // Tick.
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Run state is taken as clocks on with no reset for four cycles, so the tail is excluded.
  AST_PIN_LOW_ONLY: assert property (rst_pin_oe |-> !rst_pin_out)
    else $error("pin driven high");
  AST_OE_IN_RESET: assert property (rst_pin_oe |-> internal_reset)
    else $error("pin driven outside reset");
  AST_OE_LEN: assert property ($rose(rst_pin_oe) && !low_voltage_detect
    && !$past(low_voltage_detect) |-> ##31 rst_pin_oe ##1 !rst_pin_oe)
    else $error("pin drive length wrong");
  AST_HOLD_AFTER_PIN: assert property ($fell(rst_pin_oe)
    |-> ##31 internal_reset ##1 !internal_reset)
    else $error("reset hold length wrong");
  AST_EVT_RESET: assert property (!internal_reset && !$past(internal_reset, 4)
    && cpu_clk_run && (cpu_evt.illegal_op || (cpu_evt.opcode_fetch && cpu_evt.unmapped))
    |=> internal_reset)
    else $error("fault did not reset");
  AST_DATA_READ: assert property (!internal_reset && !$past(internal_reset, 4)
    && cpu_clk_run && cpu_evt == 4'h1 && !low_voltage_detect && rst_pin_in |=> !internal_reset)
    else $error("data read reset");
  AST_POR_START: assert property (power_on_pulse
    |=> internal_reset && osc_enable && !cpu_clk_run)
    else $error("power-on state wrong");
  AST_LOWV_HOLD: assert property (low_voltage_detect |=> internal_reset && !cpu_clk_run)
    else $error("low supply not held");
  AST_BUS_QUARTER: assert property (bus_clk_en
    |=> !bus_clk_en ##1 !bus_clk_en ##1 !bus_clk_en)
    else $error("bus tick too fast");
endmodule : rsq_reset_sequencer_checker

// ==== verif/rsq_pin_partner.sv ====
`timescale 1ns/1ps
module rsq_pin_partner (
  input  wire logic pin_out,  // Device value.
  input  wire logic pin_oe,   // Device enable.
  input  wire logic ext_low,  // Outside pull-down.
  output logic      pin_level // Wire level.
);
  // Pulled-up wire: a high drive is ignored, so only a real low pull shows.
  assign pin_level = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule : rsq_pin_partner

// ==== verif/rsq_reset_sequencer_tb.sv ====
`timescale 1ns/1ps
module rsq_reset_sequencer_tb;
  import rsq_pkg::*;
  logic         mclk, resetn, power_on_pulse, low_voltage_detect, wake_event, ext_low;
  logic         break_active, monitor_mode, rst_pin_in, rst_pin_out, rst_pin_oe;
  logic         internal_reset, osc_enable, cpu_clk_run, bus_clk_en;
  logic [7:0]   rdata;
  rsq_bus_req_t bus;
  rsq_cpu_evt_t cpu_evt;
  int           num_errors = 0, n_compared = 0, n;

  rsq_reset_sequencer #(.WD_BITS(2), .PIN_MIN_LOW_CYC(4)) dut_u (
    .mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata), .power_on_pulse(power_on_pulse),
    .low_voltage_detect(low_voltage_detect), .cpu_evt(cpu_evt), .wake_event(wake_event),
    .break_active(break_active), .monitor_mode(monitor_mode), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .internal_reset(internal_reset),
    .osc_enable(osc_enable), .cpu_clk_run(cpu_clk_run), .bus_clk_en(bus_clk_en));
  rsq_pin_partner pin_u (.pin_out(rst_pin_out), .pin_oe(rst_pin_oe), .ext_low(ext_low),
    .pin_level(rst_pin_in));

  // Quad clock at 10 MHz.
  always #50 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  // Bus strobes last one cycle; read data is looked at in the cycle after.
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk) bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  task automatic cause(input logic [7:0] e);
    rd(ADDR_CAUSE, e);
    wr(ADDR_CAUSE, 8'hFF);
  endtask : cause
  task automatic evt(input logic [3:0] e);
    @(posedge mclk) cpu_evt <= e;
    @(posedge mclk) cpu_evt <= 4'h0;
    #1;
  endtask : evt
  function automatic logic cur(input int s);
    return s == 0 ? internal_reset : (s == 1 ? rst_pin_oe : cpu_clk_run);
  endfunction : cur
  // Counts edges until an output reaches a level; a hang ends the run.
  task automatic wt(input int s, input logic lvl, input int lim, output int k);
    for (k = 0; cur(s) !== lvl; k++) begin
      if (k == lim) begin
        num_errors++;
        end_of_test();
      end
      @(posedge mclk);
      #1;
    end
  endtask : wt

  task automatic t_por();
    @(posedge mclk) power_on_pulse <= 1'b1;
    @(posedge mclk) power_on_pulse <= 1'b0;
    repeat (100) @(posedge mclk);
    #1 chk({osc_enable, cpu_clk_run, rst_pin_oe, rst_pin_in, internal_reset}, 5'h13);
    wt(0, 1'b0, 5000, n);
    chk(n >= 4055 && n <= 4063, 1);
    cause(8'h80);
  endtask : t_por
  task automatic t_int(input logic [3:0] e, input logic [7:0] f);
    wr(ADDR_CFG_ONE, 8'h00);
    evt(e);
    chk({internal_reset, rst_pin_oe, rst_pin_in}, 3'h6);
    wt(1, 1'b0, 100, n);
    chk(n, 32);
    wt(0, 1'b0, 100, n);
    chk(n, 32);
    repeat (4) @(posedge mclk);
    cause(f);
  endtask : t_int
  // A data read first, then stop and a wake; recovery length follows the short bit.
  task automatic t_stop(input logic [7:0] c, input int lo, input int hi);
    wr(ADDR_CFG_ONE, c);
    evt(4'h1);
    chk(internal_reset, 0);
    evt(4'h4);
    chk({osc_enable, cpu_clk_run, internal_reset}, 3'h0);
    repeat (10) @(posedge mclk);
    @(posedge mclk) wake_event <= 1'b1;
    @(posedge mclk) wake_event <= 1'b0;
    #1 wt(2, 1'b1, 5000, n);
    chk(n >= lo && n <= hi, 1);
  endtask : t_stop
  task automatic t_ext();
    @(posedge mclk) ext_low <= 1'b1;
    repeat (10) @(posedge mclk);
    #1 chk({internal_reset, rst_pin_oe}, 2'h2);
    @(posedge mclk) ext_low <= 1'b0;
    #1 wt(0, 1'b0, 100, n);
    cause(8'h40);
  endtask : t_ext
  // Frozen in a monitor break, then kept alive by service writes, then let run out.
  task automatic t_wdog();
    wr(ADDR_BRK_AUX, 8'h01);
    wr(ADDR_WDOG_SERVICE, 8'h00);
    @(posedge mclk) {break_active, monitor_mode} <= 2'h3;
    n = 0;
    for (int i = 0; i < 20000; i++) begin
      @(posedge mclk);
      #1 n += internal_reset;
    end
    chk(n, 0);
    @(posedge mclk) {break_active, monitor_mode} <= 2'h0;
    for (int i = 0; i < 5; i++) begin
      repeat (4000) @(posedge mclk);
      wr(ADDR_WDOG_SERVICE, 8'h5A);
    end
    cause(8'h00);
    wt(0, 1'b1, 20000, n);
    wt(0, 1'b0, 100, n);
    cause(8'h20);
  endtask : t_wdog
  task automatic t_lowv();
    @(posedge mclk) low_voltage_detect <= 1'b1;
    repeat (30) @(posedge mclk);
    #1 chk({internal_reset, cpu_clk_run}, 2'h2);
    @(posedge mclk) low_voltage_detect <= 1'b0;
    #1 wt(0, 1'b0, 5000, n);
    chk(n >= 4155 && n <= 4164, 1);
    cause(8'h02);
  endtask : t_lowv

  task automatic end_of_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence; low supply goes last because it clears the configuration.
  initial begin
    {mclk, resetn, power_on_pulse, low_voltage_detect, wake_event, ext_low} = 6'h00;
    {break_active, monitor_mode, bus, cpu_evt} = '0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    t_por();
    wr(ADDR_CFG_TWO, 8'h01);
    rd(16'h0100, 8'h00);
    t_int(4'h8, 8'h10);
    t_int(4'h4, 8'h10);
    t_int(4'h3, 8'h08);
    t_stop(8'h03, 29, 35);
    t_stop(8'h01, 4093, 4099);
    t_ext();
    t_wdog();
    t_lowv();
    end_of_test();
  end
endmodule : rsq_reset_sequencer_tb

bind rsq_reset_sequencer rsq_reset_sequencer_checker #(.WD_BITS(WD_BITS),
  .PIN_MIN_LOW_CYC(PIN_MIN_LOW_CYC)) chk_u (.mclk(mclk), .resetn(resetn), .bus(bus),
  .rdata(rdata), .power_on_pulse(power_on_pulse), .low_voltage_detect(low_voltage_detect),
  .cpu_evt(cpu_evt), .wake_event(wake_event), .break_active(break_active),
  .monitor_mode(monitor_mode), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
  .rst_pin_oe(rst_pin_oe), .internal_reset(internal_reset), .osc_enable(osc_enable),
  .cpu_clk_run(cpu_clk_run), .bus_clk_en(bus_clk_en));
